// ---- src/asd_pkg.sv ----
// package for the adc scan to ram dma block: constants and carrier types
package asd_pkg;
	localparam int unsigned RES_W        = 10;
	localparam int unsigned SLOT_W       = 16;
	localparam int unsigned NUM_CH       = 4;
	localparam int unsigned NUM_CYC      = 10;
	localparam int unsigned BUF_DEPTH    = NUM_CH * NUM_CYC;
	localparam int unsigned ADDR_W       = 6;
	localparam int unsigned CNT_W        = 6;
	localparam int unsigned CH_W         = 2;
	localparam int unsigned CONV_CYCLES  = 8;
	localparam int unsigned CONV_W       = 4;
	localparam logic [CNT_W-1:0]  CNT_DEFAULT = 6'h28;
	localparam logic [ADDR_W-1:0] ADDR_ZERO   = 6'h00;
	localparam logic [CONV_W-1:0] CONV_LAST   = 4'h7;

	typedef struct packed {
		logic              valid;
		logic [CH_W-1:0]   chan;
		logic [RES_W-1:0]  data;
	} asd_result_t;

	typedef struct packed {
		logic              we;
		logic [ADDR_W-1:0] addr;
		logic [SLOT_W-1:0] data;
	} asd_ram_wr_t;

	typedef struct packed {
		logic              start;
		logic [ADDR_W-1:0] dest;
		logic [CNT_W-1:0]  count;
	} asd_dma_cfg_t;
endpackage : asd_pkg

// ---- src/asd_scan_dma.sv ----
// adc scan sequencer, result register and single dma channel into a ram buffer
// Operation
// R01: conversion end loads result, raises done request
// R02: each done request triggers one transfer
// R03: software start scans four channels repeatedly
// R04: source fixed at result register, dest ram
// R05: transfers go to consecutive slots from start
// R06: end interrupt after programmed count completes
// R07: software reloads destination and count afterward
// R08: ten bit result stored in sixteen bit slot
// R09: start clears end request, enables, waits trigger; a start with count zero leaves the channel disabled
// R10: count decrements; zero stops triggers until restart
`timescale 1ns/100ps
module asd_scan_dma (
	input  wire logic                 i_clk_sys,     // system clock 40 MHz
	input  wire logic                 i_arst_n,      // async reset, active low
	input  wire logic                 i_adc_start,   // software trigger, one pulse
	input  wire logic                 i_adc_stop,    // stop sequential conversions
	input  wire logic [asd_pkg::RES_W-1:0] i_sample, // converter sample of current channel
	input  wire asd_pkg::asd_dma_cfg_t i_dma_cfg,    // dma start with dest and count
	output logic [asd_pkg::CH_W-1:0]  o_chan_sel,    // analog input being converted
	output asd_pkg::asd_result_t      o_result,      // result register, valid = done irq
	output asd_pkg::asd_ram_wr_t      o_ram_wr,      // write into the result buffer
	output logic                      o_dma_busy,    // channel enabled, count nonzero
	output logic                      o_dma_end_irq, // transfer end request, sticky
	output logic [asd_pkg::CNT_W-1:0] o_count        // remaining transfers
);
	import asd_pkg::*;

	function automatic logic [CNT_W-1:0] dec_cnt(input logic [CNT_W-1:0] c);
		dec_cnt = c - 6'h01;
	endfunction : dec_cnt

	////////////////////////////////////////////////////////////////////
	// converter sequencer
	typedef enum logic [0:0] {ADC_IDLE = 1'b0, ADC_RUN = 1'b1} asd_adc_st_t;
	asd_adc_st_t         adc_st_reg, adc_st_next;
	logic [CONV_W-1:0]   conv_reg, conv_next;
	logic [CH_W-1:0]     ch_reg, ch_next;
	asd_result_t         res_reg, res_next;

	always_comb begin
		adc_st_next = adc_st_reg;
		conv_next   = conv_reg;
		ch_next     = ch_reg;
		res_next    = res_reg;
		res_next.valid = 1'b0;
		unique case (adc_st_reg)
			ADC_IDLE: begin
				if (i_adc_start) begin
					adc_st_next = ADC_RUN; // R03
					conv_next   = '0;
					ch_next     = '0;
				end
			end
			ADC_RUN: begin
				if (i_adc_stop) begin
					adc_st_next = ADC_IDLE;
				end else if (conv_reg == CONV_LAST) begin
					res_next.valid = 1'b1; // R01
					res_next.chan  = ch_reg;
					res_next.data  = i_sample; // R01
					conv_next      = '0;
					ch_next        = ch_reg + 2'h1; // R03
				end else begin
					conv_next = conv_reg + 4'h1;
				end
			end
		endcase
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			adc_st_reg <= ADC_IDLE;
			conv_reg   <= '0;
			ch_reg     <= '0;
			res_reg    <= '0;
		end else begin
			adc_st_reg <= adc_st_next;
			conv_reg   <= conv_next;
			ch_reg     <= ch_next;
			res_reg    <= res_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// dma channel
	logic              en_reg, en_next;
	logic              irq_reg, irq_next;
	logic [ADDR_W-1:0] addr_reg, addr_next;
	logic [CNT_W-1:0]  cnt_reg, cnt_next;
	asd_ram_wr_t       wr_reg, wr_next;

	always_comb begin
		en_next   = en_reg;
		irq_next  = irq_reg;
		addr_next = addr_reg;
		cnt_next  = cnt_reg;
		wr_next   = wr_reg;
		wr_next.we = 1'b0;
		if (i_dma_cfg.start) begin
			// start wins over a same-cycle trigger: the old setup is gone
			irq_next  = 1'b0; // R09
			addr_next = i_dma_cfg.dest; // R07
			cnt_next  = i_dma_cfg.count; // R07
			en_next   = (i_dma_cfg.count != '0); // R09
		end else if (en_reg && res_reg.valid) begin // R02
			wr_next.we   = 1'b1;
			wr_next.addr = addr_reg; // R05
			wr_next.data = {{(SLOT_W-RES_W){1'b0}}, res_reg.data}; // R04 R08
			addr_next    = addr_reg + 6'h01; // R05
			cnt_next     = dec_cnt(cnt_reg); // R10
			if (cnt_reg == 6'h01) begin
				en_next  = 1'b0; // R10
				irq_next = 1'b1; // R06
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			en_reg   <= 1'b0;
			irq_reg  <= 1'b0;
			addr_reg <= ADDR_ZERO;
			cnt_reg  <= CNT_DEFAULT;
			wr_reg   <= '0;
		end else begin
			en_reg   <= en_next;
			irq_reg  <= irq_next;
			addr_reg <= addr_next;
			cnt_reg  <= cnt_next;
			wr_reg   <= wr_next;
		end
	end

	assign o_chan_sel    = ch_reg;
	assign o_result      = res_reg;
	assign o_ram_wr      = wr_reg;
	assign o_dma_busy    = en_reg;
	assign o_dma_end_irq = irq_reg;
	assign o_count       = cnt_reg;

	////////////////////////////////////////////////////////////////////
	// assertions
	property p_done_period;
		@(posedge i_clk_sys) disable iff (!i_arst_n)
		res_reg.valid |=> (!res_reg.valid) [*7];
	endproperty
	a_done_period: assert property (p_done_period) else $error("done too soon"); // R01

	property p_trig_write;
		@(posedge i_clk_sys) disable iff (!i_arst_n)
		(en_reg && res_reg.valid && !i_dma_cfg.start) |=>
			(wr_reg.we && wr_reg.data[RES_W-1:0] == $past(res_reg.data));
	endproperty
	a_trig_write: assert property (p_trig_write) else $error("missed transfer"); // R02

	property p_chan_step;
		@(posedge i_clk_sys) disable iff (!i_arst_n)
		(res_reg.valid && adc_st_reg == ADC_RUN) |-> ch_reg == res_reg.chan + 2'h1;
	endproperty
	a_chan_step: assert property (p_chan_step) else $error("scan order"); // R03

	property p_upper_zero;
		@(posedge i_clk_sys) disable iff (!i_arst_n)
		wr_reg.we |-> wr_reg.data[SLOT_W-1:RES_W] == '0;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("slot upper bits"); // R08

	property p_addr_inc;
		@(posedge i_clk_sys) disable iff (!i_arst_n)
		(wr_reg.we && !$past(i_dma_cfg.start)) |-> addr_reg == wr_reg.addr + 6'h01;
	endproperty
	a_addr_inc: assert property (p_addr_inc) else $error("addr step"); // R05

	property p_end_irq;
		@(posedge i_clk_sys) disable iff (!i_arst_n)
		(en_reg && res_reg.valid && !i_dma_cfg.start && cnt_reg == 6'h01) |=>
			(irq_reg && !en_reg && cnt_reg == '0);
	endproperty
	a_end_irq: assert property (p_end_irq) else $error("no end irq"); // R06

	property p_start_clr;
		@(posedge i_clk_sys) disable iff (!i_arst_n)
		(i_dma_cfg.start && i_dma_cfg.count != '0) |=> (!irq_reg && en_reg);
	endproperty
	a_start_clr: assert property (p_start_clr) else $error("start setup"); // R09

	property p_idle_nowrite;
		@(posedge i_clk_sys) disable iff (!i_arst_n)
		!en_reg |=> !wr_reg.we;
	endproperty
	a_idle_nowrite: assert property (p_idle_nowrite) else $error("write when stopped"); // R10

	property p_cnt_dec;
		@(posedge i_clk_sys) disable iff (!i_arst_n)
		wr_reg.we && !$past(i_dma_cfg.start) |-> cnt_reg == dec_cnt($past(cnt_reg));
	endproperty
	a_cnt_dec: assert property (p_cnt_dec) else $error("count step"); // R10

	property p_stop_wins;
		@(posedge i_clk_sys) disable iff (!i_arst_n)
		(adc_st_reg == ADC_RUN && i_adc_stop) |=> (!res_reg.valid && adc_st_reg == ADC_IDLE);
	endproperty
	a_stop_wins: assert property (p_stop_wins) else $error("conversion after stop"); // R03

	property p_idle_novalid;
		@(posedge i_clk_sys) disable iff (!i_arst_n)
		(adc_st_reg == ADC_IDLE) |=> !res_reg.valid;
	endproperty
	a_idle_novalid: assert property (p_idle_novalid) else $error("result when idle"); // R01

	// a start must land dest and count exactly as given, whatever was pending
	property p_start_load;
		@(posedge i_clk_sys) disable iff (!i_arst_n)
		i_dma_cfg.start |=>
			(addr_reg == $past(i_dma_cfg.dest) && cnt_reg == $past(i_dma_cfg.count));
	endproperty
	a_start_load: assert property (p_start_load) else $error("start load"); // R09

	property p_irq_hold;
		@(posedge i_clk_sys) disable iff (!i_arst_n)
		(irq_reg && !i_dma_cfg.start) |=> irq_reg;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("end request lost"); // R06

	c_transfer: cover property (@(posedge i_clk_sys) disable iff (!i_arst_n) wr_reg.we);
	c_end: cover property (@(posedge i_clk_sys) disable iff (!i_arst_n) $rose(irq_reg));
	c_wrap: cover property (@(posedge i_clk_sys) disable iff (!i_arst_n)
		res_reg.valid && res_reg.chan == 2'h3);
	c_restart: cover property (@(posedge i_clk_sys) disable iff (!i_arst_n)
		irq_reg ##1 i_dma_cfg.start);
endmodule : asd_scan_dma

// ---- sim/asd_far_model.sv ----
// far side model: analog inputs of the converter and the result buffer ram
`timescale 1ns/100ps
module asd_far_model (
	input  wire logic                      i_clk_sys,  // system clock
	input  wire logic [asd_pkg::CH_W-1:0]  i_chan_sel, // channel being converted
	input  wire asd_pkg::asd_ram_wr_t      i_ram_wr,   // buffer write
	output logic      [asd_pkg::RES_W-1:0] o_sample    // converter sample
);
	import asd_pkg::*;
	logic [SLOT_W-1:0] mem [64];
	int                wr_count = 0;
	// each channel gives its own value so a misrouted slot shows
	assign o_sample = {i_chan_sel, 8'ha5};
	always @(posedge i_clk_sys) begin
		if (i_ram_wr.we === 1'b1) begin
			mem[i_ram_wr.addr] <= i_ram_wr.data;
			wr_count <= wr_count + 1;
		end
	end
endmodule : asd_far_model

// ---- sim/asd_scan_dma_bench.sv ----
// self-checking bench for the adc scan to ram dma block
`timescale 1ns/100ps
module asd_scan_dma_bench;
	import asd_pkg::*;
	logic             clk = 0, arst_n = 0, go = 0, halt = 0, busy, irq;
	logic [RES_W-1:0] smp;
	asd_dma_cfg_t     cfg = '0;
	logic [CH_W-1:0]  chs;
	asd_result_t      res;
	asd_ram_wr_t      wr;
	logic [CNT_W-1:0] cnt;
	int               errors = 0, check_count = 0, cycles = 0;
	asd_scan_dma asd_scan_dma_i (.i_clk_sys(clk), .i_arst_n(arst_n), .i_adc_start(go),
		.i_adc_stop(halt), .i_sample(smp), .i_dma_cfg(cfg), .o_chan_sel(chs),
		.o_result(res), .o_ram_wr(wr), .o_dma_busy(busy), .o_dma_end_irq(irq),
		.o_count(cnt));
	asd_far_model asd_far_model_i (.i_clk_sys(clk), .i_chan_sel(chs), .i_ram_wr(wr),
		.o_sample(smp));
	initial forever #12.5 clk = ~clk;
	// a whole round is about 330 cycles, so this leaves wide margin
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			errors++;
			report_and_stop();
		end
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic report_and_stop();
		if (errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop
	task automatic dma_go(input logic [5:0] d, input logic [5:0] c);
		@(negedge clk) cfg = {1'b1, d, c};
		@(negedge clk) cfg.start = 1'b0;
	endtask : dma_go
	task automatic adc_go();
		@(negedge clk) go = 1'b1;
		@(negedge clk) go = 1'b0;
		for (int i = 0; i < 400 && irq !== 1'b1; i++) @(negedge clk);
		// the last slot lands in the ram one edge after the end request
		@(negedge clk);
	endtask : adc_go
	task automatic t_slots(input int base, input int n);
		for (int k = 0; k < n; k++)
			chk("slot", {6'h0, k[1:0], 8'ha5}, asd_far_model_i.mem[base + k]);
	endtask : t_slots
	////////////////////////////////////////////////////////////////////////////
	task automatic t_round();
		int n;
		dma_go(6'h00, CNT_DEFAULT);
		chk("busy", 16'h1, {15'h0, busy});
		adc_go();
		chk("irq", 16'h1, {15'h0, irq});
		chk("count", 16'h0, {10'h0, cnt});
		t_slots(0, 40);
		n = asd_far_model_i.wr_count;
		chk("write total", 16'(BUF_DEPTH), 16'(n));
		repeat (40) @(negedge clk);
		chk("writes", 16'(n), 16'(asd_far_model_i.wr_count));
	endtask : t_round
	task automatic t_reload();
		@(negedge clk) halt = 1'b1;
		@(negedge clk) halt = 1'b0;
		dma_go(6'h08, 6'h04);
		chk("irq", 16'h0, {15'h0, irq});
		chk("count", 16'h4, {10'h0, cnt});
		adc_go();
		chk("irq", 16'h1, {15'h0, irq});
		t_slots(8, 4);
		dma_go(6'h00, 6'h00);
		chk("busy", 16'h0, {15'h0, busy});
	endtask : t_reload
	task automatic t_scan();
		int n;
		int v;
		n = 0;
		v = 0;
		@(negedge clk) halt = 1'b1;
		@(negedge clk) halt = 1'b0;
		repeat (16) begin
			if (res.valid === 1'b1) v++;
			@(negedge clk);
		end
		chk("valid after stop", 16'h0, 16'(v));
		@(negedge clk) go = 1'b1;
		@(negedge clk) go = 1'b0;
		while (res.valid !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		chk("first latency", 16'(CONV_CYCLES), 16'(n));
		chk("result chan", 16'h0, {14'h0, res.chan});
		chk("result data", 16'h00a5, {6'h0, res.data});
		@(negedge clk);
		chk("valid pulse", 16'h0, {15'h0, res.valid});
	endtask : t_scan
	initial begin
		repeat (2) @(negedge clk);
		arst_n = 1'b1;
		chk("count", 16'h28, {10'h0, cnt});
		t_round();
		t_reload();
		t_scan();
		report_and_stop();
	end
endmodule : asd_scan_dma_bench
